// ===== design/data_space_access_unit.v
/*
 Data space access unit: working registers, address generation for one X
 read, one Y read and one combined write per cycle, an 8 KB byte-split
 RAM with a dual-ported DMA window, and misaligned word trapping.
 Assumes the CPU pipeline and DMA controller run on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "data_space_defines.vh"
// Functional notes
// [RULE1] Post-increment adds one per byte, two per word
// [RULE2] Byte read picks byte by LSB, low lane
// [RULE3] Two byte halves, shared decode, separate strobes
// [RULE4] Odd word access raises address error trap; Y reads at odd addresses are not trapped
// [RULE5] Read completes, write suppressed, then trap
// [RULE6] Byte load writes only register low byte
// [RULE7] Sign extend byte to sixteen bits
// [RULE8] Zero extend clears register upper byte
// [RULE9] Low 2 KB is register space, gaps read zero
// [RULE10] Near region reached by 13-bit address field
// [RULE11] Whole space via 16-bit direct or pointer
// [RULE12] Two address generators read two words together
// [RULE13] X read bus serves combined and prefetch reads
// [RULE14] Y read only for multiply-accumulate class
// [RULE15] Modulo on X and Y; bit-reverse X writes only
// [RULE16] Writes use combined range; fixed X/Y boundary
// [RULE17] Sixteen-bit byte addresses, 64 KB range
// [RULE18] 2 KB dual-ported RAM atop Y space
// [RULE19] DMA accesses never stall the CPU
// [RULE20] CPU write wins same-location collision
// [RULE21] Unimplemented addresses read zero
// [RULE22] Top address bit routes to visibility window
// [RULE23] Colliding DMA write is discarded
module data_space_access_unit (
   input  wire        sys_clk,
   input  wire        rst_n,
   input  wire        xr_req,
   input  wire [1:0]  xr_mode,
   input  wire [15:0] xr_addr,
   input  wire [3:0]  xr_ptr,
   input  wire        xr_byte,
   output reg  [15:0] xr_data_q,
   output reg         xr_valid_q,
   input  wire        yr_req,
   input  wire        multiply_accumulate_class,
   input  wire [3:0]  yr_ptr,
   output reg  [15:0] yr_data_q,
   output reg         yr_valid_q,
   input  wire        xw_req,
   input  wire [1:0]  xw_mode,
   input  wire [15:0] xw_addr,
   input  wire [3:0]  xw_ptr,
   input  wire        xw_byte,
   input  wire [15:0] xw_data,
   input  wire        upd_en,
   input  wire [3:0]  upd_sel,
   input  wire        upd_byte,
   input  wire        upd_mod_en,
   input  wire        upd_brev,
   input  wire [15:0] mod_start,
   input  wire [15:0] mod_end,
   input  wire [15:0] brev_mod,
   input  wire [1:0]  reg_op,
   input  wire [3:0]  reg_sel,
   input  wire [7:0]  reg_byte,
   input  wire [3:0]  rd_sel,
   output reg  [15:0] wreg_rd_q,
   input  wire        dma_req,
   input  wire        dma_we,
   input  wire [9:0]  dma_addr,
   input  wire [15:0] dma_wdata,
   output reg  [15:0] dma_rdata_q,
   output reg         addr_err_q,
   output reg  [15:0] err_addr_q,
   output reg         psv_sel_q,
   output reg  [15:0] psv_addr_q
);

   reg  [15:0] wreg_q [0:15];
   reg  [7:0]  ram_lo [0:`DSA_RAM_WORDS-1];
   reg  [7:0]  ram_hi [0:`DSA_RAM_WORDS-1];

   reg  [15:0] xr_ea;
   reg  [15:0] yr_ea;
   reg  [15:0] xw_ea;
   reg         xr_mis;
   reg         xw_mis;
   reg         xw_ok;
   reg         yr_go;
   reg  [11:0] xw_idx;
   reg  [11:0] dma_idx;
   reg         dma_wr_ok;
   reg  [15:0] upd_d;
   integer     i;

   function [15:0] bit_rev;
      input [15:0] v;
      integer k;
      begin
         for (k = 0; k < 16; k = k + 1) begin
            bit_rev[k] = v[15-k];
         end
      end
   endfunction

   // Address generator shared by the X read and X write ports
   function [15:0] calc_ea;
      input [1:0]  mode;
      input [15:0] addr;
      input [15:0] ptr_val;
      begin
         case (mode)
            `DSA_MODE_NEAR: calc_ea = {3'h0, addr[12:0]}; // RULE10
            `DSA_MODE_IND:  calc_ea = ptr_val; // RULE11
            default:        calc_ea = addr; // RULE11
         endcase
      end
   endfunction

   function in_ram;
      input [15:0] ea;
      begin
         in_ram = (ea >= `DSA_RAM_BASE) && (ea <= `DSA_RAM_END);
      end
   endfunction

   function [11:0] ram_idx;
      input [15:0] ea;
      reg   [15:0] off;
      begin
         off     = ea - `DSA_RAM_BASE;
         ram_idx = off[12:1];
      end
   endfunction

   // Whole word at the aligned address; holes and upper half read zero
   function [15:0] fetch;
      input [15:0] ea;
      begin
         if (ea[15]) begin
            fetch = 16'h0000; // RULE22
         end else if (ea <= `DSA_WREG_END) begin
            fetch = wreg_q[ea[4:1]];
         end else if (in_ram(ea)) begin
            fetch = {ram_hi[ram_idx(ea)], ram_lo[ram_idx(ea)]};
         end else begin
            fetch = 16'h0000; // RULE9 RULE21
         end
      end
   endfunction

   function [15:0] lane;
      input [15:0] w;
      input        byte_op;
      input        lsb;
      begin
         if (!byte_op) begin
            lane = w;
         end else if (lsb) begin
            lane = {8'h00, w[15:8]}; // RULE2
         end else begin
            lane = {8'h00, w[7:0]}; // RULE2
         end
      end
   endfunction

   always @* begin
      xr_ea   = calc_ea(xr_mode, xr_addr, wreg_q[xr_ptr]);
      yr_ea   = wreg_q[yr_ptr];
      xw_ea   = calc_ea(xw_mode, xw_addr, wreg_q[xw_ptr]);
      xr_mis  = xr_req && !xr_byte && xr_ea[0]; // RULE4
      xw_mis  = xw_req && !xw_byte && xw_ea[0]; // RULE4
      xw_ok   = xw_req && !xw_mis && !xw_ea[15]; // RULE5 RULE16
      yr_go   = yr_req && multiply_accumulate_class; // RULE14
      xw_idx  = ram_idx(xw_ea);
      dma_idx = ram_idx(`DSA_DMA_BASE) + {2'h0, dma_addr}; // RULE18
      // Same-word CPU write removes the DMA write altogether
      dma_wr_ok = dma_req && dma_we &&
                  !(xw_ok && in_ram(xw_ea) && xw_idx == dma_idx); // RULE23
   end

   // Pointer post-modify: reverse-carry step, modulo wrap, or plain byte/word step
   always @* begin
      if (upd_brev) begin
         upd_d = bit_rev(bit_rev(wreg_q[upd_sel]) +
                         bit_rev(brev_mod)); // RULE15
      end else if (upd_mod_en && wreg_q[upd_sel] == mod_end) begin
         upd_d = mod_start; // RULE15
      end else if (upd_byte) begin
         upd_d = wreg_q[upd_sel] + `DSA_BYTE_STEP; // RULE1
      end else begin
         upd_d = wreg_q[upd_sel] + `DSA_WORD_STEP; // RULE1
      end
   end

   // Working registers: bus write, then pointer update, then register op
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         for (i = 0; i < 15; i = i + 1) begin
            wreg_q[i] <= `DSA_WREG_RST;
         end
         wreg_q[15] <= `DSA_W15_RST;
      end else begin
         if (xw_ok && xw_ea <= `DSA_WREG_END) begin
            if (!xw_byte || !xw_ea[0]) begin
               wreg_q[xw_ea[4:1]][7:0] <= xw_byte ? xw_data[7:0]
                                                  : xw_data[7:0]; // RULE3
            end
            if (!xw_byte) begin
               wreg_q[xw_ea[4:1]][15:8] <= xw_data[15:8]; // RULE3
            end else if (xw_ea[0]) begin
               wreg_q[xw_ea[4:1]][15:8] <= xw_data[7:0]; // RULE3
            end
         end
         if (upd_en) begin
            wreg_q[upd_sel] <= upd_d; // RULE1
         end
         case (reg_op)
            `DSA_OP_BYTE: begin
               wreg_q[reg_sel][7:0] <= reg_byte; // RULE6
            end
            `DSA_OP_SIGN: begin
               wreg_q[reg_sel] <= {{8{wreg_q[reg_sel][7]}},
                                   wreg_q[reg_sel][7:0]}; // RULE7
            end
            `DSA_OP_ZERO: begin
               wreg_q[reg_sel][15:8] <= 8'h00; // RULE8
            end
            default: begin
            end
         endcase
      end
   end

   // Byte halves share the word index; DMA first so the CPU lands last
   always @(posedge sys_clk) begin
      if (dma_wr_ok) begin
         ram_lo[dma_idx] <= dma_wdata[7:0]; // RULE18 RULE19
         ram_hi[dma_idx] <= dma_wdata[15:8]; // RULE18 RULE19
      end
      if (xw_ok && in_ram(xw_ea)) begin
         if (!xw_byte || !xw_ea[0]) begin
            ram_lo[xw_idx] <= xw_data[7:0]; // RULE3 RULE20
         end
         if (!xw_byte) begin
            ram_hi[xw_idx] <= xw_data[15:8]; // RULE3 RULE20
         end else if (xw_ea[0]) begin
            ram_hi[xw_idx] <= xw_data[7:0]; // RULE3 RULE20
         end
      end
   end

   // Arrays are read here at the edge; a comb copy would miss writes
   // Read answers, one cycle after the request
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         xr_data_q   <= 16'h0000;
         xr_valid_q  <= 1'b0;
         yr_data_q   <= 16'h0000;
         yr_valid_q  <= 1'b0;
         dma_rdata_q <= 16'h0000;
         wreg_rd_q   <= 16'h0000;
         psv_sel_q   <= 1'b0;
         psv_addr_q  <= 16'h0000;
      end else begin
         xr_valid_q <= xr_req; // RULE13
         if (xr_req) begin
            xr_data_q <= lane(fetch(xr_ea), xr_byte,
                              xr_ea[0]); // RULE2 RULE13
         end
         yr_valid_q <= yr_go; // RULE12
         if (yr_go) begin
            yr_data_q <= (yr_ea >= `DSA_Y_BASE) ? fetch(yr_ea)
                                                : 16'h0000; // RULE12 RULE14
         end
         if (dma_req) begin
            dma_rdata_q <= {ram_hi[dma_idx], ram_lo[dma_idx]}; // RULE19
         end
         wreg_rd_q <= wreg_q[rd_sel];
         psv_sel_q <= xr_req && xr_ea[15]; // RULE22
         if (xr_req && xr_ea[15]) begin
            psv_addr_q <= xr_ea; // RULE17 RULE22
         end
      end
   end

   // Trap follows the faulting access; the fault address is kept
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         addr_err_q <= 1'b0;
         err_addr_q <= 16'h0000;
      end else begin
         addr_err_q <= xr_mis || xw_mis; // RULE4 RULE5
         if (xw_mis) begin
            err_addr_q <= xw_ea; // RULE5
         end else if (xr_mis) begin
            err_addr_q <= xr_ea; // RULE5
         end
      end
   end

endmodule
`default_nettype wire

// ===== pkg/data_space_defines.vh
/*
 Constants for the data space access unit: map boundaries, reset values,
 pointer steps and operation codes. Assumes a byte-addressed 16-bit space.
*/
`ifndef DATA_SPACE_DEFINES_VH
`define DATA_SPACE_DEFINES_VH
`define DSA_SFR_END     16'h07ff
`define DSA_NEAR_END    16'h1fff
`define DSA_WREG_END    16'h001f
`define DSA_RAM_BASE    16'h0800
`define DSA_RAM_END     16'h27ff
`define DSA_Y_BASE      16'h1800
`define DSA_DMA_BASE    16'h2000
`define DSA_RAM_WORDS   4096
`define DSA_DMA_WORDS   1024
`define DSA_WREG_RST    16'h0000
`define DSA_W15_RST     16'h0800
`define DSA_BYTE_STEP   16'h0001
`define DSA_WORD_STEP   16'h0002
`define DSA_MODE_DIRECT 2'h0
`define DSA_MODE_NEAR   2'h1
`define DSA_MODE_IND    2'h2
`define DSA_OP_NONE     2'h0
`define DSA_OP_BYTE     2'h1
`define DSA_OP_SIGN     2'h2
`define DSA_OP_ZERO     2'h3
`endif

// ===== test/dsa_asserts.sv
/*
 Port checker for the data space access unit.
 Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
`default_nettype none
module dsa_chk (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        xr_req,
   input wire logic [1:0]  xr_mode,
   input wire logic [15:0] xr_addr,
   input wire logic        xr_byte,
   input wire logic [15:0] xr_data_q,
   input wire logic        xr_valid_q,
   input wire logic        yr_req,
   input wire logic        multiply_accumulate_class,
   input wire logic        yr_valid_q,
   input wire logic        xw_req,
   input wire logic        addr_err_q,
   input wire logic        psv_sel_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire dir = xr_req && xr_mode == 2'h0;
   wire y_ok = yr_req && multiply_accumulate_class;
   AST_X_ANSWER:
      assert property (xr_req |=> xr_valid_q) else $error("no x answer");
   AST_X_PULSE:
      assert property (!xr_req |=> !xr_valid_q) else $error("stray x valid");
   AST_Y_ANSWER:
      assert property (y_ok |=> yr_valid_q) else $error("no y answer");
   AST_Y_REFUSE:
      assert property (!y_ok |=> !yr_valid_q) else $error("stray y valid");
   AST_ODD_TRAP:
      assert property (dir && !xr_byte && xr_addr[0] |=> addr_err_q)
         else $error("odd word read not trapped");
   AST_NO_TRAP:
      assert property (!xr_req && !xw_req && !yr_req |=> !addr_err_q)
         else $error("trap without access");
   AST_BYTE_LANE:
      assert property (xr_req && xr_byte |=> xr_data_q[15:8] == 8'h00)
         else $error("byte read upper lane set");
   AST_PSV:
      assert property (dir && xr_addr[15] |=> psv_sel_q && xr_data_q == 16'h0)
         else $error("visibility window missed");
   AST_SFR_GAP:
      assert property (dir && xr_addr >= 16'h0020 && xr_addr <= 16'h07ff
         |=> xr_data_q == 16'h0000) else $error("register gap not zero");
   cover property (y_ok ##1 yr_valid_q);
   cover property (dir && xr_addr[15]);
   cover property (addr_err_q);
endmodule
bind data_space_access_unit dsa_chk dsa_chk_i (
   .sys_clk                   (sys_clk),
   .rst_n                     (rst_n),
   .xr_req                    (xr_req),
   .xr_mode                   (xr_mode),
   .xr_addr                   (xr_addr),
   .xr_byte                   (xr_byte),
   .xr_data_q                 (xr_data_q),
   .xr_valid_q                (xr_valid_q),
   .yr_req                    (yr_req),
   .multiply_accumulate_class (multiply_accumulate_class),
   .yr_valid_q                (yr_valid_q),
   .xw_req                    (xw_req),
   .addr_err_q                (addr_err_q),
   .psv_sel_q                 (psv_sel_q)
);
`default_nettype wire

// ===== test/dma_model.sv
/*
 DMA controller model: one transfer per call, no grant awaited.
 Assumes the caller starts each call between clock edges.
*/
`timescale 1ns/1ns
`default_nettype none
module dma_model (
   input  wire logic        sys_clk,
   input  wire logic [15:0] dma_rdata_q,
   output var  logic        dma_req,
   output var  logic        dma_we,
   output var  logic [9:0]  dma_addr,
   output var  logic [15:0] dma_wdata
);
   initial begin
      dma_req = 1'b0;
      dma_we = 1'b0;
      dma_addr = 10'h000;
      dma_wdata = 16'h0000;
   end
   // Idle address and data are inverted and dma_req, dma_we drop low, so a stale value never looks valid
   task xfer(input w, input [9:0] a, input [15:0] d, output [15:0] r);
      @(negedge sys_clk);
      dma_req = 1'b1;
      dma_we = w;
      dma_addr = a;
      dma_wdata = d;
      @(negedge sys_clk);
      r = dma_rdata_q;
      dma_req = 1'b0;
      dma_we = 1'b0;
      dma_addr = ~a;
      dma_wdata = ~d;
   endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
/*
 Self-checking bench for the data space access unit.
 Assumes dma_model stands in for the DMA controller.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic sys_clk = 0, rst_n = 0, xr_req = 0, xr_byte = 0, yr_req = 0;
   logic multiply_accumulate_class = 0, xw_req = 0, xw_byte = 0;
   logic upd_en = 0, upd_byte = 0, upd_mod_en = 0, upd_brev = 0;
   logic dma_req, dma_we, xr_valid_q, yr_valid_q, addr_err_q, psv_sel_q;
   logic [1:0] xr_mode = 0, xw_mode = 0, reg_op = 0;
   logic [3:0] xr_ptr = 0, yr_ptr = 0, xw_ptr = 0, upd_sel = 0;
   logic [3:0] reg_sel = 0, rd_sel = 15;
   logic [7:0] reg_byte = 0;
   logic [9:0] dma_addr;
   logic [15:0] xr_addr = 0, xw_addr = 0, xw_data = 0, brev_mod = 0;
   logic [15:0] mod_start = 0, mod_end = 0, dma_wdata, xr_data_q, yr_data_q;
   logic [15:0] wreg_rd_q, dma_rdata_q, err_addr_q, psv_addr_q, got;
   integer miscompares = 0;
   integer comparisons = 0;
   data_space_access_unit data_space_access_unit_i (.*);
   dma_model dma_m (.*);
   always #25 sys_clk = ~sys_clk;
   task chk(input [15:0] g, input [15:0] e);
      comparisons = comparisons + 1;
      if (g !== e) begin
         miscompares = miscompares + 1;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task tally_and_finish;
      if (miscompares == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task rd(input [1:0] m, input [15:0] a, input b, input [1:0] y,
           input [15:0] e);
      @(negedge sys_clk);
      xr_req = 1'b1;
      xr_mode = m;
      xr_addr = a;
      xr_byte = b;
      yr_req = y[0];
      multiply_accumulate_class = y[1];
      @(negedge sys_clk);
      xr_req = 1'b0;
      yr_req = 1'b0;
      chk(xr_valid_q, 16'h0001);
      chk(xr_data_q, e);
   endtask
   task wr(input [1:0] m, input [15:0] a, input b, input [15:0] d);
      @(negedge sys_clk);
      xw_req = 1'b1;
      xw_mode = m;
      xw_addr = a;
      xw_byte = b;
      xw_data = d;
      @(negedge sys_clk);
      xw_req = 1'b0;
   endtask
   // Register copy lags one cycle, so the check waits an extra edge
   task wreg(input u, input b, input mo, input [1:0] o, input [7:0] v,
             input [15:0] e);
      @(negedge sys_clk);
      upd_en = u;
      upd_byte = b;
      upd_mod_en = mo;
      reg_op = o;
      reg_byte = v;
      @(negedge sys_clk);
      upd_en = 1'b0;
      reg_op = 2'h0;
      @(negedge sys_clk);
      chk(wreg_rd_q, e);
   endtask
   task s_align;
      @(negedge sys_clk);
      chk(wreg_rd_q, 16'h0800);
      wr(2'h0, 16'h0800, 1'b0, 16'h1111);
      wr(2'h0, 16'h0802, 1'b0, 16'h2222);
      wr(2'h0, 16'h0801, 1'b0, 16'hbeef);
      chk(addr_err_q, 16'h0001);
      chk(err_addr_q, 16'h0801);
      rd(2'h0, 16'h0801, 1'b0, 2'h0, 16'h1111);
      chk(addr_err_q, 16'h0001);
      wr(2'h0, 16'h0803, 1'b1, 16'h77ab);
      rd(2'h0, 16'h0802, 1'b0, 2'h0, 16'hab22);
      rd(2'h0, 16'h0803, 1'b1, 2'h0, 16'h00ab);
      rd(2'h0, 16'h0802, 1'b1, 2'h0, 16'h0022);
   endtask
   task s_ptr;
      wr(2'h0, 16'h0002, 1'b0, 16'h1000);
      upd_sel = 4'h1;
      reg_sel = 4'h1;
      rd_sel = 4'h1;
      mod_start = 16'h1000;
      mod_end = 16'h1003;
      wreg(1'b1, 1'b1, 1'b1, 2'h0, 8'h00, 16'h1001);
      wreg(1'b1, 1'b0, 1'b1, 2'h0, 8'h00, 16'h1003);
      wreg(1'b1, 1'b0, 1'b1, 2'h0, 8'h00, 16'h1000);
      wreg(1'b0, 1'b0, 1'b0, 2'h1, 8'h85, 16'h1085);
      wreg(1'b0, 1'b0, 1'b0, 2'h2, 8'h00, 16'hff85);
      wreg(1'b0, 1'b0, 1'b0, 2'h3, 8'h00, 16'h0085);
      brev_mod = 16'h0008;
      upd_brev = 1'b1;
      wreg(1'b1, 1'b0, 1'b0, 2'h0, 8'h00, 16'h008d);
      upd_brev = 1'b0;
   endtask
   task s_map;
      rd(2'h0, 16'h0100, 1'b0, 2'h0, 16'h0000);
      rd(2'h1, 16'he802, 1'b0, 2'h0, 16'hab22);
      rd(2'h0, 16'h2800, 1'b0, 2'h0, 16'h0000);
      rd(2'h0, 16'h8002, 1'b0, 2'h0, 16'h0000);
      chk(psv_sel_q, 16'h0001);
      chk(psv_addr_q, 16'h8002);
   endtask
   task s_dual;
      wr(2'h0, 16'h0004, 1'b0, 16'h1800);
      xw_ptr = 4'h2;
      xr_ptr = 4'h2;
      yr_ptr = 4'h2;
      wr(2'h2, 16'h0000, 1'b0, 16'h1234);
      rd(2'h2, 16'h0000, 1'b0, 2'h3, 16'h1234);
      chk(yr_valid_q, 16'h0001);
      chk(yr_data_q, 16'h1234);
      rd(2'h0, 16'h1800, 1'b0, 2'h1, 16'h1234);
      chk(yr_valid_q, 16'h0000);
   endtask
   task s_dma;
      fork
         dma_m.xfer(1'b1, 10'h005, 16'haaaa, got);
         wr(2'h0, 16'h200a, 1'b0, 16'h5555);
      join
      rd(2'h0, 16'h200a, 1'b0, 2'h0, 16'h5555);
      dma_m.xfer(1'b0, 10'h005, 16'h0000, got);
      chk(got, 16'h5555);
      fork
         dma_m.xfer(1'b1, 10'h005, 16'haaaa, got);
         wr(2'h0, 16'h200a, 1'b1, 16'h0066);
      join
      rd(2'h0, 16'h200a, 1'b0, 2'h0, 16'h5566);
      fork
         dma_m.xfer(1'b1, 10'h006, 16'hc3c3, got);
         rd(2'h0, 16'h0800, 1'b0, 2'h0, 16'h1111);
      join
      rd(2'h0, 16'h200c, 1'b0, 2'h0, 16'hc3c3);
   endtask
   initial begin
      repeat (3000) @(posedge sys_clk);
      miscompares = miscompares + 1;
      tally_and_finish;
   end
   initial begin
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      s_align;
      s_ptr;
      s_map;
      s_dual;
      s_dma;
      tally_and_finish;
   end
endmodule
`default_nettype wire
